// [rtl/atg_pkg.sv]
// Shared constants for the link, tone generator and speaker gain registers
package atg_pkg;
   // Register offsets on the control port
   localparam logic [15:0] ADDR_RX_EN_LOW   = 16'h2070;
   localparam logic [15:0] ADDR_RX_EN_HIGH  = 16'h2071;
   localparam logic [15:0] ADDR_TX_CTRL     = 16'h2072;
   localparam logic [15:0] ADDR_LINK_EN     = 16'h207F;
   localparam logic [15:0] ADDR_TONE_CFG    = 16'h2083;
   localparam logic [15:0] ADDR_DC_UPPER    = 16'h2084;
   localparam logic [15:0] ADDR_DC_MIDDLE   = 16'h2085;
   localparam logic [15:0] ADDR_DC_LOWER    = 16'h2086;
   localparam logic [15:0] ADDR_TONE_CLK    = 16'h2087;
   localparam logic [15:0] ADDR_TONE_EN     = 16'h208F;
   localparam logic [15:0] ADDR_SPK_VOLUME  = 16'h2090;
   localparam logic [15:0] ADDR_SPEAKER_GAIN_CODE    = 16'h2091;

   // Reset values
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_TONE_CFG  = 8'h04;
   localparam logic [7:0] RST_SPEAKER_GAIN_CODE  = 8'h0B;

   // Writable bit masks, reserved bits read as zero
   localparam logic [7:0] MASK_TX_CTRL  = 8'h1F;
   localparam logic [7:0] MASK_LINK_EN  = 8'h03;
   localparam logic [7:0] MASK_TONE_CFG = 8'h3F;
   localparam logic [7:0] MASK_BIT0     = 8'h01;
   localparam logic [7:0] MASK_VOLUME   = 8'h7F;
   localparam logic [7:0] MASK_FULL     = 8'hFF;

   // Field positions
   localparam int LINK_EN_BIT      = 1;
   localparam int LINK_TX_EN_BIT   = 0;
   localparam int PAYLOAD_SEL_BIT  = 4;
   localparam int DEST_LSB         = 0;
   localparam int DEST_MSB         = 3;
   localparam int CFG_MODE_LSB     = 0;
   localparam int CFG_MODE_MSB     = 3;
   localparam int CFG_AMP_LSB      = 4;
   localparam int CFG_AMP_MSB      = 5;
   localparam int GAIN_LSB         = 4;
   localparam int GAIN_MSB         = 7;

   // Audio word sizes
   localparam logic [1:0] WORD_16 = 2'h0;
   localparam logic [1:0] WORD_24 = 2'h1;
   localparam logic [1:0] WORD_32 = 2'h2;

   // Generator modes
   localparam logic [3:0] GEN_DC_PROG  = 4'h0;
   localparam logic [3:0] GEN_ZERO     = 4'h1;
   localparam logic [3:0] GEN_POS_HALF = 4'h2;
   localparam logic [3:0] GEN_NEG_HALF = 4'h3;
   localparam logic [3:0] GEN_TONE_1K  = 4'h4;
   localparam logic [3:0] GEN_FS_4     = 4'h5;
   localparam logic [3:0] GEN_FS_6     = 4'h6;

   // Sample levels, 24-bit signed full scale
   localparam logic [23:0] HALF_POS = 24'h400000;
   localparam logic [23:0] HALF_NEG = 24'hC00000;
   localparam logic [23:0] SAT_POS  = 24'h7FFFFF;
   localparam logic [23:0] SAT_NEG  = 24'h800000;

   // Sine amplitude scales, unsigned Q15
   localparam logic [15:0] AMP_M6DB   = 16'h4027;
   localparam logic [15:0] AMP_M4P8DB = 16'h49A7;
   localparam logic [15:0] AMP_0DB    = 16'h7FFF;
   localparam logic [15:0] AMP_NONE   = 16'h0000;
   localparam logic [1:0]  AMP_CODE_M6   = 2'h0;
   localparam logic [1:0]  AMP_CODE_M4P8 = 2'h1;
   localparam logic [1:0]  AMP_CODE_0    = 2'h2;
   localparam int          AMP_SHIFT     = 7;

   // Sine table of twelve phases per period
   localparam logic [3:0] PHASES     = 4'hC;
   localparam logic [3:0] LAST_PHASE = 4'hB;
   localparam logic [3:0] STEP_FS4   = 4'h3;
   localparam logic [3:0] STEP_FS6   = 4'h2;

   // Speaker gain in half-dB steps
   localparam logic [7:0] GAIN_BIAS   = 8'h0C;
   localparam logic [7:0] STEPS_6DB   = 8'h0C;
   localparam logic [3:0] GAIN_LAST_LINEAR = 4'h8;
   localparam logic [3:0] GAIN_CODE_5DB    = 4'h9;
   localparam logic [3:0] GAIN_CODE_6DB    = 4'hA;
   localparam logic [7:0] HALF_STEPS_5DB   = 8'h0A;
   localparam logic [7:0] HALF_STEPS_6DB   = 8'h0C;
   localparam logic [6:0] VOL_FLOOR        = 7'h7E;
   localparam int         FRAC_SHIFT       = 13;
endpackage

// [rtl/atg_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module atg_regs
   import atg_pkg::*;
#(
   parameter logic [15:0] TONE_STEP_DIV = 16'h0100 // Ticks per 1kHz phase
)
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Control port
   input  wire logic [15:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output var  logic [7:0]  reg_rdata,
   // Link receive
   input  wire logic        link_rx_valid,
   input  wire logic [3:0]  link_rx_channel,
   input  wire logic [23:0] link_rx_data,
   output var  logic        link_rx_accept,
   output var  logic [23:0] link_rx_word,
   // Link transmit
   input  wire logic [1:0]  audio_word_size,
   input  wire logic        link_tx_slot,
   input  wire logic [23:0] headroom_tracking,
   input  wire logic [23:0] foldback_data,
   output var  logic        link_active,
   output var  logic        link_tx_drive_en,
   output var  logic [3:0]  link_tx_destination,
   output var  logic        link_tx_valid,
   output var  logic [23:0] link_tx_payload,
   // Generator clocks
   input  wire logic        internal_oscillator_clock,
   input  wire logic        bclk_pin,
   // Speaker path
   input  wire logic        sample_tick,
   input  wire logic        pcm_valid,
   input  wire logic [23:0] pcm_sample,
   output var  logic        spk_valid,
   output var  logic [23:0] spk_sample
);
   // Stored registers
   logic [7:0]  rx_low_reg;      // Channels 7..0
   logic [7:0]  rx_high_reg;     // Channels 15..8
   logic [7:0]  tx_ctrl_reg;     // Payload select and destination
   logic [7:0]  link_en_reg;     // Link and transmitter enables
   logic [7:0]  tone_cfg_reg;    // Amplitude and mode
   logic [7:0]  dc_upper_reg;    // DC bits 23..16
   logic [7:0]  dc_middle_reg;   // DC bits 15..8
   logic [7:0]  dc_lower_reg;    // DC bits 7..0
   logic [7:0]  tone_clk_reg;    // Generator clock source
   logic [7:0]  tone_en_reg;     // Generator replaces serial input
   logic [7:0]  volume_reg;      // Speaker volume code
   logic [7:0]  gain_reg;        // Gain code; low nibble stored but unused
   logic [15:0] link_rx_channel_enable; // All sixteen enables
   logic [15:0] chan_ok;         // Per-channel accept term

   // Generator state
   logic        bclk_meta_reg;   // First synchroniser stage
   logic        bclk_sync_reg;   // Second synchroniser stage
   logic        bclk_prev_reg;   // For edge detection
   logic        gen_tick;        // One tick of the chosen source
   logic [15:0] div_reg;         // Divider toward 1kHz phase step
   logic [3:0]  ph_1k_reg;       // 1kHz tone phase
   logic [3:0]  ph_fs_reg;       // Per-sample phase for fs tones
   logic [3:0]  fs_step;         // Phase stride for the fs tones
   logic [3:0]  rom_phase;       // Table address
   logic signed [15:0] sine_reg; // Table read data
   logic        tick_d_reg;      // Sample tick aligned to table data
   logic [15:0] amp_scale;       // Selected sine amplitude
   logic signed [31:0] sine_prod;  // Scaled sine product
   logic        gen_valid_reg;   // Generator sample strobe
   logic [23:0] gen_sample_reg;  // Generator sample
   logic [3:0]  gen_mode;        // Generator mode field

   // Speaker path
   logic        src_valid;       // Selected source strobe
   logic [23:0] src_sample;      // Selected source sample
   logic [7:0]  atten_steps;     // Half-dB steps plus bias
   logic [3:0]  shift_amt;       // Whole 6dB steps
   logic [3:0]  frac_idx;        // Residual half-dB steps
   logic signed [40:0] spk_prod;   // Sample times fraction
   logic signed [40:0] spk_shift;  // After attenuation shift

   // Address match, used by both write and read decode
   function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
      hit = (a == b);
   endfunction

   // Gain code to half-dB steps; reserved codes give no gain
   function automatic logic [7:0] gain_steps(input logic [3:0] code);
      if (code <= GAIN_LAST_LINEAR) begin
         gain_steps = {4'h0, code};
      end else if (code == GAIN_CODE_5DB) begin
         gain_steps = HALF_STEPS_5DB;
      end else if (code == GAIN_CODE_6DB) begin
         gain_steps = HALF_STEPS_6DB;
      end else begin
         gain_steps = 8'h00;
      end
   endfunction

   // Two to the minus k over twelve, Q14
   function automatic logic [15:0] frac_q14(input logic [3:0] k);
      case (k)
         4'h0:    frac_q14 = 16'h4000;
         4'h1:    frac_q14 = 16'h3C68;
         4'h2:    frac_q14 = 16'h3904;
         4'h3:    frac_q14 = 16'h35D1;
         4'h4:    frac_q14 = 16'h32CC;
         4'h5:    frac_q14 = 16'h2FF2;
         4'h6:    frac_q14 = 16'h2D41;
         4'h7:    frac_q14 = 16'h2AB7;
         4'h8:    frac_q14 = 16'h2851;
         4'h9:    frac_q14 = 16'h260E;
         4'hA:    frac_q14 = 16'h23EB;
         4'hB:    frac_q14 = 16'h21E7;
         default: frac_q14 = 16'h4000;
      endcase
   endfunction

   // Register writes, reserved bits masked off
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_low_reg    <= RST_ZERO;
         rx_high_reg   <= RST_ZERO;
         tx_ctrl_reg   <= RST_ZERO;
         link_en_reg   <= RST_ZERO;
         tone_cfg_reg  <= RST_TONE_CFG;
         dc_upper_reg  <= RST_ZERO;
         dc_middle_reg <= RST_ZERO;
         dc_lower_reg  <= RST_ZERO;
         tone_clk_reg  <= RST_ZERO;
         tone_en_reg   <= RST_ZERO;
         volume_reg    <= RST_ZERO;
         gain_reg      <= RST_SPEAKER_GAIN_CODE;
      end else if (reg_wr) begin
         if (hit(reg_addr, ADDR_RX_EN_LOW))
            rx_low_reg <= reg_wdata & MASK_FULL;
         if (hit(reg_addr, ADDR_RX_EN_HIGH))
            rx_high_reg <= reg_wdata & MASK_FULL;
         if (hit(reg_addr, ADDR_TX_CTRL))
            tx_ctrl_reg <= reg_wdata & MASK_TX_CTRL;
         if (hit(reg_addr, ADDR_LINK_EN))
            link_en_reg <= reg_wdata & MASK_LINK_EN;
         if (hit(reg_addr, ADDR_TONE_CFG))
            tone_cfg_reg <= reg_wdata & MASK_TONE_CFG;
         if (hit(reg_addr, ADDR_DC_UPPER))
            dc_upper_reg <= reg_wdata & MASK_FULL;
         if (hit(reg_addr, ADDR_DC_MIDDLE))
            dc_middle_reg <= reg_wdata & MASK_FULL;
         if (hit(reg_addr, ADDR_DC_LOWER))
            dc_lower_reg <= reg_wdata & MASK_FULL;
         if (hit(reg_addr, ADDR_TONE_CLK))
            tone_clk_reg <= reg_wdata & MASK_BIT0;
         if (hit(reg_addr, ADDR_TONE_EN))
            tone_en_reg <= reg_wdata & MASK_BIT0;
         if (hit(reg_addr, ADDR_SPK_VOLUME))
            volume_reg <= reg_wdata & MASK_VOLUME;
         if (hit(reg_addr, ADDR_SPEAKER_GAIN_CODE))
            gain_reg <= reg_wdata & MASK_FULL;
      end
   end

   // Registered read data; unmapped addresses read zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= RST_ZERO;
      end else if (reg_rd) begin
         case (1'b1)
            hit(reg_addr, ADDR_RX_EN_LOW):  reg_rdata <= rx_low_reg;
            hit(reg_addr, ADDR_RX_EN_HIGH): reg_rdata <= rx_high_reg;
            hit(reg_addr, ADDR_TX_CTRL):    reg_rdata <= tx_ctrl_reg;
            hit(reg_addr, ADDR_LINK_EN):    reg_rdata <= link_en_reg;
            hit(reg_addr, ADDR_TONE_CFG):   reg_rdata <= tone_cfg_reg;
            hit(reg_addr, ADDR_DC_UPPER):   reg_rdata <= dc_upper_reg;
            hit(reg_addr, ADDR_DC_MIDDLE):  reg_rdata <= dc_middle_reg;
            hit(reg_addr, ADDR_DC_LOWER):   reg_rdata <= dc_lower_reg;
            hit(reg_addr, ADDR_TONE_CLK):   reg_rdata <= tone_clk_reg;
            hit(reg_addr, ADDR_TONE_EN):    reg_rdata <= tone_en_reg;
            hit(reg_addr, ADDR_SPK_VOLUME): reg_rdata <= volume_reg;
            hit(reg_addr, ADDR_SPEAKER_GAIN_CODE):   reg_rdata <= gain_reg;
            default:                        reg_rdata <= RST_ZERO;
         endcase
      end
   end

   // Link state straight from the enable, transmit control and receive enable registers
   always_comb begin
      link_active         = link_en_reg[LINK_EN_BIT];
      link_tx_drive_en    = link_en_reg[LINK_EN_BIT] &
                            link_en_reg[LINK_TX_EN_BIT];
      link_tx_destination = tx_ctrl_reg[DEST_MSB:DEST_LSB];
      link_rx_channel_enable = {rx_high_reg, rx_low_reg};
   end

   genvar ch;
   generate
      for (ch = 0; ch < 16; ch++) begin : g_chan
         assign chan_ok[ch] = link_rx_channel_enable[ch] &
                              (link_rx_channel == 4'(ch));
      end
   endgenerate

   // Receive: a word on a disabled channel is dropped silently
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         link_rx_accept <= 1'b0;
         link_rx_word   <= 24'h000000;
      end else begin
         link_rx_accept <= link_rx_valid & link_active & (|chan_ok);
         if (link_rx_valid && link_active && (|chan_ok))
            link_rx_word <= link_rx_data;
      end
   end

   // Transmit payload, loaded on each link slot while the transmitter is driven
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         link_tx_valid   <= 1'b0;
         link_tx_payload <= 24'h000000;
      end else begin
         link_tx_valid <= link_tx_slot & link_tx_drive_en;
         if (link_tx_slot && link_tx_drive_en) begin
            if (audio_word_size == WORD_16 &&
                tx_ctrl_reg[PAYLOAD_SEL_BIT])
               link_tx_payload <= foldback_data;
            else
               link_tx_payload <= headroom_tracking;
         end
      end
   end

   // Bit clock pin is asynchronous: two flops before any use
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bclk_meta_reg <= 1'b0;
         bclk_sync_reg <= 1'b0;
         bclk_prev_reg <= 1'b0;
      end else begin
         bclk_meta_reg <= bclk_pin;
         bclk_sync_reg <= bclk_meta_reg;
         bclk_prev_reg <= bclk_sync_reg;
      end
   end

   assign gen_tick = tone_clk_reg[0] ? (bclk_sync_reg & ~bclk_prev_reg)
                                     : internal_oscillator_clock;

   // 1kHz phase advances on source ticks, independent of sample rate
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         div_reg   <= 16'h0000;
         ph_1k_reg <= 4'h0;
      end else if (gen_tick) begin
         if (div_reg >= TONE_STEP_DIV - 16'h0001) begin
            div_reg   <= 16'h0000;
            ph_1k_reg <= (ph_1k_reg == LAST_PHASE) ? 4'h0
                                                   : ph_1k_reg + 4'h1;
         end else begin
            div_reg <= div_reg + 16'h0001;
         end
      end
   end

   // Per-sample phase for the fs/4 and fs/6 tones
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ph_fs_reg  <= 4'h0;
         tick_d_reg <= 1'b0;
      end else begin
         tick_d_reg <= sample_tick;
         // Stride wraps modulo twelve table phases
         if (sample_tick)
            ph_fs_reg <= (ph_fs_reg + fs_step >= PHASES)
                         ? ph_fs_reg + fs_step - PHASES
                         : ph_fs_reg + fs_step;
      end
   end

   assign gen_mode = tone_cfg_reg[CFG_MODE_MSB:CFG_MODE_LSB];
   assign fs_step  = (gen_mode == GEN_FS_6) ? STEP_FS6 : STEP_FS4;

   // Table address by mode
   always_comb begin
      case (gen_mode)
         GEN_FS_4, GEN_FS_6: rom_phase = ph_fs_reg;
         default:  rom_phase = ph_1k_reg;
      endcase
   end

   atg_sine_rom u_rom (
      .core_clk (core_clk),
      .phase    (rom_phase),
      .sine_reg (sine_reg)
   );

   // Amplitude code; reserved code mutes the tone
   always_comb begin
      case (tone_cfg_reg[CFG_AMP_MSB:CFG_AMP_LSB])
         AMP_CODE_M6:   amp_scale = AMP_M6DB;
         AMP_CODE_M4P8: amp_scale = AMP_M4P8DB;
         AMP_CODE_0:    amp_scale = AMP_0DB;
         default:       amp_scale = AMP_NONE;
      endcase
      sine_prod = sine_reg * $signed({1'b0, amp_scale[14:0]});
   end

   // Generator sample, one per sample tick after table read
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         gen_valid_reg  <= 1'b0;
         gen_sample_reg <= 24'h000000;
      end else begin
         gen_valid_reg <= tick_d_reg;
         if (tick_d_reg) begin
            case (gen_mode)
               GEN_DC_PROG:
                  gen_sample_reg <= {dc_upper_reg, dc_middle_reg,
                                     dc_lower_reg};
               GEN_ZERO:     gen_sample_reg <= 24'h000000;
               GEN_POS_HALF: gen_sample_reg <= HALF_POS;
               GEN_NEG_HALF: gen_sample_reg <= HALF_NEG;
               GEN_TONE_1K, GEN_FS_4, GEN_FS_6:
                  gen_sample_reg <= sine_prod[AMP_SHIFT +: 24];
               default:      gen_sample_reg <= 24'h000000;
            endcase
         end
      end
   end

   // Source switch for the speaker path
   assign src_valid  = tone_en_reg[0] ? gen_valid_reg  : pcm_valid;
   assign src_sample = tone_en_reg[0] ? gen_sample_reg : pcm_sample;

   // Net attenuation in half-dB steps, biased so gain stays positive
   always_comb begin
      atten_steps = ((volume_reg[6:0] > VOL_FLOOR) ? {1'b0, VOL_FLOOR}
                                                   : volume_reg)
                    + GAIN_BIAS
                    - gain_steps(gain_reg[GAIN_MSB:GAIN_LSB]);
      shift_amt   = 4'(atten_steps / STEPS_6DB);
      frac_idx    = 4'(atten_steps % STEPS_6DB);
      spk_prod    = $signed(src_sample) *
                    $signed({1'b0, frac_q14(frac_idx)});
      spk_shift   = spk_prod >>> (FRAC_SHIFT + shift_amt);
   end

   // Scaled output with saturation; gain can overflow full scale
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         spk_valid  <= 1'b0;
         spk_sample <= 24'h000000;
      end else begin
         spk_valid <= src_valid;
         if (src_valid) begin
            if (spk_shift > $signed({17'h0, SAT_POS}))
               spk_sample <= SAT_POS;
            else if (spk_shift < $signed({{17{1'b1}}, SAT_NEG}))
               spk_sample <= SAT_NEG;
            else
               spk_sample <= spk_shift[23:0];
         end
      end
   end
endmodule
`default_nettype wire

// [rtl/atg_sine_rom.sv]
`timescale 1ns/100ps
`default_nettype none
// Twelve-phase sine table, Q15, read data registered
module atg_sine_rom
   import atg_pkg::*;
(
   input  wire logic               core_clk,
   input  wire logic        [3:0]  phase,
   output var  logic signed [15:0] sine_reg
);
   logic signed [15:0] sine_next; // Table value for this phase

   // Table lookup, one sample per 30 degrees
   always_comb begin
      case (phase)
         4'h0:    sine_next = 16'sh0000;
         4'h1:    sine_next = 16'sh4000;
         4'h2:    sine_next = 16'sh6ED9;
         4'h3:    sine_next = 16'sh7FFF;
         4'h4:    sine_next = 16'sh6ED9;
         4'h5:    sine_next = 16'sh4000;
         4'h6:    sine_next = 16'sh0000;
         4'h7:    sine_next = 16'shC000;
         4'h8:    sine_next = 16'sh9127;
         4'h9:    sine_next = 16'sh8001;
         4'hA:    sine_next = 16'sh9127;
         4'hB:    sine_next = 16'shC000;
         default: sine_next = 16'sh0000;
      endcase
   end

   // Registered read port, no reset needed for table data
   always_ff @(posedge core_clk) begin
      sine_reg <= sine_next;
   end
endmodule
`default_nettype wire

// [sim/atg_peer_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Peer amplifier on the shared link
module atg_peer_model (
   input  wire logic        core_clk,
   output var  logic        link_rx_valid,
   output var  logic [3:0]  link_rx_channel,
   output var  logic [23:0] link_rx_data,
   output var  logic        link_tx_slot
);
   // One word in one channel; data inverts after so stale never matches
   task automatic send(input logic [3:0] ch, input logic [23:0] d);
      @(posedge core_clk);
      link_rx_valid <= 1'b1;
      link_rx_channel <= ch;
      link_rx_data <= d;
      @(posedge core_clk);
      link_rx_valid <= 1'b0;
      link_rx_data <= ~d;
   endtask
   // Ask the device for its payload
   task automatic slot();
      @(posedge core_clk);
      link_tx_slot <= 1'b1;
      @(posedge core_clk);
      link_tx_slot <= 1'b0;
   endtask
   initial begin
      link_rx_valid = 1'b0;
      link_rx_channel = 4'h0;
      link_rx_data = 24'h000000;
      link_tx_slot = 1'b0;
   end
endmodule
`default_nettype wire

// [sim/atg_regs_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
// Port checker for the link and speaker path
module atg_regs_monitor
   import atg_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        link_rx_valid,
   input wire logic [23:0] link_rx_data,
   input wire logic        link_rx_accept,
   input wire logic [23:0] link_rx_word,
   input wire logic        link_active,
   input wire logic        link_tx_drive_en,
   input wire logic        link_tx_slot,
   input wire logic        link_tx_valid,
   input wire logic [1:0]  audio_word_size,
   input wire logic [23:0] headroom_tracking,
   input wire logic [23:0] link_tx_payload,
   input wire logic        pcm_valid,
   input wire logic        sample_tick,
   input wire logic        spk_valid
);
   // One clock domain, reset masks all checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_rx_src;
      link_rx_accept |-> $past(link_rx_valid) && $past(link_active);
   endproperty
   a_rx_src: assert property (p_rx_src)
      else $error("accept without a live word");
   property p_rx_word;
      link_rx_accept |-> link_rx_word == $past(link_rx_data);
   endproperty
   a_rx_word: assert property (p_rx_word)
      else $error("accepted word differs");
   property p_rx_off;
      link_rx_valid && !link_active |=> !link_rx_accept;
   endproperty
   a_rx_off: assert property (p_rx_off)
      else $error("accept while link off");
   property p_drive;
      link_tx_drive_en |-> link_active;
   endproperty
   a_drive: assert property (p_drive)
      else $error("driver on while link off");
   property p_tx_go;
      link_tx_slot && link_tx_drive_en |=> link_tx_valid;
   endproperty
   a_tx_go: assert property (p_tx_go)
      else $error("slot not answered");
   property p_tx_src;
      link_tx_valid |-> $past(link_tx_slot) && $past(link_tx_drive_en);
   endproperty
   a_tx_src: assert property (p_tx_src)
      else $error("payload sent unasked");
   property p_tx_wide;
      link_tx_valid && $past(audio_word_size) != WORD_16
         |-> link_tx_payload == $past(headroom_tracking);
   endproperty
   a_tx_wide: assert property (p_tx_wide)
      else $error("wide words must carry headroom");
   property p_spk_src;
      spk_valid |-> $past(pcm_valid) || $past(sample_tick, 3);
   endproperty
   a_spk_src: assert property (p_spk_src)
      else $error("speaker sample without source");
endmodule
bind atg_regs atg_regs_monitor atg_regs_monitor_inst (.core_clk, .rst_n,
   .link_rx_valid, .link_rx_data, .link_rx_accept, .link_rx_word,
   .link_active, .link_tx_drive_en, .link_tx_slot, .link_tx_valid,
   .audio_word_size, .headroom_tracking, .link_tx_payload, .pcm_valid,
   .sample_tick, .spk_valid);
`default_nettype wire

// [sim/tb_amp_link_tone_gain_regs.sv]
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the link, tone and gain registers
module tb_amp_link_tone_gain_regs;
   import atg_pkg::*;
   logic core_clk, rst_n, reg_wr, reg_rd, sample_tick, pcm_valid;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata;
   logic [1:0]  audio_word_size;
   logic [23:0] pcm_sample, link_rx_data, link_rx_word;
   logic [23:0] link_tx_payload, spk_sample;
   logic [3:0]  link_rx_channel, link_tx_destination;
   logic link_rx_valid, link_rx_accept, link_active, link_tx_drive_en;
   logic link_tx_slot, link_tx_valid, spk_valid;
   int fail_count = 0;
   int cmp_count = 0;
   // Address, reset value, write value, readback
   localparam logic [39:0] ROWS [11] = '{40'h2070_00_5A_5A,
      40'h2071_00_3C_3C, 40'h2072_00_FF_1F, 40'h207F_00_FF_03,
      40'h2083_04_FF_3F, 40'h2084_00_A5_A5, 40'h2087_00_FF_01,
      40'h208F_00_FF_01, 40'h2090_00_FF_7F, 40'h2091_0B_5A_5A,
      40'h2073_00_FF_00};
   atg_regs #(.TONE_STEP_DIV(16'h0002)) atg_regs_inst (.core_clk, .rst_n,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_rx_valid,
      .link_rx_channel, .link_rx_data, .link_rx_accept, .link_rx_word,
      .audio_word_size, .link_tx_slot, .headroom_tracking(24'h0A0A0A),
      .foldback_data(24'h0F0F0F), .link_active, .link_tx_drive_en,
      .link_tx_destination, .link_tx_valid, .link_tx_payload,
      .internal_oscillator_clock(1'b1), .bclk_pin(1'b0), .sample_tick,
      .pcm_valid, .pcm_sample, .spk_valid, .spk_sample);
   atg_peer_model atg_peer_model_inst (.core_clk, .link_rx_valid,
      .link_rx_channel, .link_rx_data, .link_tx_slot);
   task automatic chk(input logic [23:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (fail_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk({16'h0000, reg_rdata}, {16'h0000, e});
   endtask
   // Peer word, then accept flag and held word
   task automatic rx(input logic [3:0] c, input logic [23:0] d, w,
                     input logic a);
      atg_peer_model_inst.send(c, d);
      #1 chk({23'h0, link_rx_accept}, {23'h0, a});
      chk(link_rx_word, w);
   endtask
   task automatic tx(input logic v, input logic [23:0] e);
      atg_peer_model_inst.slot();
      #1 chk({23'h0, link_tx_valid}, {23'h0, v});
      if (v) chk(link_tx_payload, e);
   endtask
   task automatic pcm(input logic [23:0] x, e, input logic v);
      @(posedge core_clk);
      pcm_sample <= x;
      pcm_valid <= 1'b1;
      @(posedge core_clk);
      pcm_valid <= 1'b0;
      #1 chk({23'h0, spk_valid}, {23'h0, v});
      if (v) chk(spk_sample, e);
   endtask
   // Generator sample lands three edges after the tick
   task automatic tick(input logic [23:0] e);
      @(posedge core_clk);
      sample_tick <= 1'b1;
      @(posedge core_clk);
      sample_tick <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk({23'h0, spk_valid}, 24'h000001);
      chk(spk_sample, e);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Whole run is under two hundred cycles
   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, sample_tick, pcm_valid} = 5'h00;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      audio_word_size = WORD_16;
      pcm_sample = 24'h000000;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (ROWS[i]) begin
         rd(ROWS[i][39:24], ROWS[i][23:16]);
         wr(ROWS[i][39:24], ROWS[i][15:8]);
         rd(ROWS[i][39:24], ROWS[i][7:0]);
      end
      wr(ADDR_RX_EN_LOW, 8'h01);
      wr(ADDR_RX_EN_HIGH, 8'h80);
      wr(ADDR_LINK_EN, 8'h02);
      rx(4'h0, 24'hABCDEF, 24'hABCDEF, 1'b1);
      rx(4'h1, 24'h111111, 24'hABCDEF, 1'b0);
      rx(4'hF, 24'h0F0F0F, 24'h0F0F0F, 1'b1);
      wr(ADDR_LINK_EN, 8'h00);
      rx(4'h0, 24'h222222, 24'h0F0F0F, 1'b0);
      wr(ADDR_TX_CTRL, 8'h1A);
      wr(ADDR_LINK_EN, 8'h03);
      tx(1'b1, 24'h0F0F0F);
      chk({20'h0, link_tx_destination}, 24'h00000A);
      @(posedge core_clk);
      audio_word_size <= WORD_24;
      tx(1'b1, 24'h0A0A0A);
      wr(ADDR_LINK_EN, 8'h02);
      tx(1'b0, 24'h0A0A0A);
      chk({22'h0, link_active, link_tx_drive_en}, 24'h000002);
      wr(ADDR_TONE_EN, 8'h00);
      wr(ADDR_SPK_VOLUME, 8'h00);
      wr(ADDR_SPEAKER_GAIN_CODE, 8'h00);
      pcm(24'h123456, 24'h123456, 1'b1);
      wr(ADDR_SPEAKER_GAIN_CODE, 8'hA0);
      pcm(24'h123456, 24'h2468AC, 1'b1);
      wr(ADDR_SPEAKER_GAIN_CODE, 8'hB0);
      pcm(24'h123456, 24'h123456, 1'b1);
      wr(ADDR_SPEAKER_GAIN_CODE, 8'h00);
      wr(ADDR_SPK_VOLUME, 8'h0C);
      pcm(24'h123456, 24'h091A2B, 1'b1);
      wr(ADDR_SPK_VOLUME, 8'h00);
      wr(ADDR_DC_UPPER, 8'h12);
      wr(ADDR_DC_MIDDLE, 8'h34);
      wr(ADDR_DC_LOWER, 8'h56);
      wr(ADDR_TONE_CFG, 8'h30);
      wr(ADDR_TONE_EN, 8'h01);
      pcm(24'h654321, 24'h000000, 1'b0);
      tick(24'h123456);
      wr(ADDR_TONE_CFG, 8'h02);
      tick(24'h400000);
      wr(ADDR_TONE_CFG, 8'h03);
      tick(24'hC00000);
      wr(ADDR_TONE_CFG, 8'h01);
      tick(24'h000000);
      wr(ADDR_TONE_CFG, 8'h25);
      tick(24'h000000);
      tick(24'h7FFE00);
      finish_test();
   end
endmodule
`default_nettype wire
